// ---- iomb_pkg.sv ----
package iomb_pkg;

  // Register bus geometry
  localparam int unsigned REG_ADDR_W = 20;
  localparam int unsigned REG_DATA_W = 32;
  localparam logic [REG_ADDR_W-1:0] MBOX_OFFSET     = 20'h1D290;
  localparam logic [REG_ADDR_W-1:0] ALERT_EN_OFFSET = 20'h1D284;

  // Reset values and port count
  localparam logic [31:0] MBOX_RESET = 32'h0000_0000;
  localparam int unsigned NUM_PORTS = 13;
  localparam logic [NUM_PORTS-1:0] ALERT_EN_RESET = 13'h1FFF;

  // Port n enable sits at printed bit 31-n, which is bit n counted from the LSB
  localparam int unsigned ALERT_EN_LSB = 0;

  // Peripheral byte addresses seen by the external master, and the byte it reads outside them
  localparam logic [7:0] LINK_MBOX_BASE = 8'h90;
  localparam logic [7:0] LINK_MBOX_LAST = 8'h93;
  localparam logic [7:0] LINK_IDLE_BYTE = 8'h00;

  // Core cycles between two mailbox crossings; must exceed the link's capture
  // time of about three link clock periods, or two toggles could cancel
  localparam int unsigned UPD_HOLDOFF = 16;

endpackage

// ---- iomb_xfer_if.sv ----
`timescale 1ns/1ps
interface iomb_xfer_if;
  logic        upd_tgl;
  logic [31:0] upd_data;
  logic        drain_tgl;

  modport core (output upd_tgl, output upd_data, input drain_tgl);
  modport link (input upd_tgl, input upd_data, output drain_tgl);
endinterface

// ---- iomb_link.sv ----
`timescale 1ns/1ps
module iomb_link (
  // Link clock and reset
  input  wire logic       link_clk,
  input  wire logic       rst,
  // Byte-level slave events on the link clock
  input  wire logic       link_start,
  input  wire logic       link_stop,
  input  wire logic       link_rd_strobe,
  input  wire logic       link_wr_strobe,
  input  wire logic [7:0] link_addr,
  // Crossing to the core
  iomb_xfer_if.link       xfer,
  // Read data toward the master
  output logic      [7:0] link_rdata
);
  import iomb_pkg::*;

  typedef struct packed {
    logic        rst_s1;
    logic        rst_s2;
    logic        upd_s1;
    logic        upd_s2;
    logic        upd_s3;
    logic [31:0] shadow;
    logic        rd_seen;
    logic        drain_tgl;
    logic [7:0]  rdata;
  } iomb_link_state_t;

  iomb_link_state_t q;
  iomb_link_state_t d;
  logic             in_box;
  logic [1:0]       lane;

  assign in_box = (link_addr >= LINK_MBOX_BASE) && (link_addr <= LINK_MBOX_LAST);
  assign lane   = link_addr[1:0] - LINK_MBOX_BASE[1:0];

  always_comb begin
    d = q;
    d.rst_s1 = rst;
    d.rst_s2 = q.rst_s1;
    d.upd_s1 = xfer.upd_tgl;
    d.upd_s2 = q.upd_s1;
    d.upd_s3 = q.upd_s2;
    if (q.upd_s2 != q.upd_s3) begin
      d.shadow = xfer.upd_data;
    end
    // Master writes never reach the shadow word
    if (link_start) begin
      d.rd_seen = 1'b0;
    end
    if (link_rd_strobe) begin
      d.rdata = in_box ? q.shadow[8'd31 - {lane, 3'b000} -: 8] : LINK_IDLE_BYTE;
      if (in_box) begin
        d.rd_seen = 1'b1;
      end
    end
    if (link_stop) begin
      if (q.rd_seen) begin
        d.drain_tgl = ~q.drain_tgl;
      end
      d.rd_seen = 1'b0;
    end
    if (q.rst_s2) begin
      d.upd_s2    = 1'b0;
      d.upd_s3    = 1'b0;
      d.shadow    = MBOX_RESET;
      d.rd_seen   = 1'b0;
      d.drain_tgl = 1'b0;
      d.rdata     = LINK_IDLE_BYTE;
    end
  end

  always_ff @(posedge link_clk) begin
    q <= d;
  end

  assign xfer.drain_tgl = q.drain_tgl;
  assign link_rdata     = q.rdata;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (q.rst_s2);

  a_master_write_ignored: assert property (
    link_wr_strobe && (q.upd_s2 == q.upd_s3) |=> $stable(q.shadow))
    else $error("master write changed the mailbox shadow");
  a_stop_without_read: assert property (
    link_stop && !q.rd_seen && !d.rst_s2 |=> $stable(q.drain_tgl))
    else $error("drain signalled without a mailbox read");
  a_byte_lane_map: assert property (
    link_rd_strobe && (link_addr == 8'h91) |=> q.rdata == $past(q.shadow[23:16]))
    else $error("wrong byte for address 0x91");

  c_mailbox_read_stop: cover property (link_rd_strobe && in_box ##[1:40] link_stop);
endmodule

// ---- iomb_top.sv ----
`timescale 1ns/1ps
// Behaviour
// - Each of ports 12 down to 0 may set the alert only while its enable bit is 1.
// - The port alert enables are read/write and come out of reset all set.
// - Enables only gate a status 0-to-1 edge; enabling an already set status counts as an edge.
// - The outgoing mailbox is one 32-bit word that resets to zero.
// - Software reads and writes the mailbox on the register bus at offset 0x1D290.
// - The external master can only read the mailbox; its writes change nothing.
// - The master sees the mailbox as byte addresses 0x90 to 0x93.
// - Every software write to the mailbox sets the full flag.
// - A completed external read clears the full flag, except when a software write to the mailbox lands in the same core cycle.
// - A completed read raises the drained interrupt only if the full flag was set.
// - A read completes at STOP after at least one mailbox byte was read since START.
module iomb_top (
  // Core clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Register bus
  input  wire logic [iomb_pkg::REG_ADDR_W-1:0] reg_addr,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [iomb_pkg::REG_DATA_W-1:0] reg_wdata,
  output logic      [iomb_pkg::REG_DATA_W-1:0] reg_rdata,
  output logic                               reg_rvalid,
  // Port status levels and alert
  input  wire logic [iomb_pkg::NUM_PORTS-1:0]  port_status,
  output logic                               alert_flag_set,
  // Mailbox flags
  output logic                               outbound_box_full_flag,
  output logic                               outbound_box_drained_irq,
  // Link side, byte-level slave events
  input  wire logic                          link_clk,
  input  wire logic                          link_start,
  input  wire logic                          link_stop,
  input  wire logic                          link_rd_strobe,
  input  wire logic                          link_wr_strobe,
  input  wire logic [7:0]                    link_addr,
  output logic      [7:0]                    link_rdata
);
  import iomb_pkg::*;

  typedef struct packed {
    logic [31:0]          mbox;
    logic                 full;
    logic                 irq;
    logic [NUM_PORTS-1:0] en;
    logic [NUM_PORTS-1:0] gated_prev;
    logic                 alert;
    logic [31:0]          rdata;
    logic                 rvalid;
    logic                 upd_tgl;
    logic                 upd_pend;
    logic [4:0]           hold;
    logic                 drn_s1;
    logic                 drn_s2;
    logic                 drn_s3;
  } iomb_top_state_t;

  iomb_top_state_t      q;
  iomb_top_state_t      d;
  iomb_xfer_if          xfer ();
  logic                 sel_mbox;
  logic                 sel_en;
  logic                 drain_evt;
  logic [NUM_PORTS-1:0] gated;

  assign sel_mbox  = (reg_addr == MBOX_OFFSET);
  assign sel_en    = (reg_addr == ALERT_EN_OFFSET);
  assign drain_evt = q.drn_s2 ^ q.drn_s3;

  ////////////////////////////////////////////////////////////////////////////
  // Per-port gate; status stays untouched, only its rising gated level counts
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
      assign gated[gi] = port_status[gi] & q.en[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.drn_s1 = xfer.drain_tgl;
    d.drn_s2 = q.drn_s1;
    d.drn_s3 = q.drn_s2;

    // Alert: a 0-to-1 step of status AND enable, so raising an enable also fires
    d.gated_prev = gated;
    d.alert      = |(gated & ~q.gated_prev);

    // Drain first so that a same-cycle software write wins the flag
    d.irq = 1'b0;
    if (drain_evt) begin
      d.full = 1'b0;
      d.irq  = q.full;
    end

    // A word changed while the link captures it is sent again after the hold-off
    if (q.hold != 5'h00) begin
      d.hold = q.hold - 5'h01;
    end
    if (q.upd_pend && (q.hold == 5'h00)) begin
      d.upd_tgl  = ~q.upd_tgl;
      d.upd_pend = 1'b0;
      d.hold     = 5'(UPD_HOLDOFF);
    end

    if (reg_wr && sel_mbox) begin
      d.mbox     = reg_wdata;
      d.full     = 1'b1;
      d.upd_pend = 1'b1;
    end
    if (reg_wr && sel_en) begin
      d.en = reg_wdata[ALERT_EN_LSB +: NUM_PORTS];
    end

    d.rvalid = reg_rd;
    d.rdata  = 32'h0000_0000;
    if (reg_rd && sel_mbox) begin
      d.rdata = q.mbox;
    end else if (reg_rd && sel_en) begin
      d.rdata[ALERT_EN_LSB +: NUM_PORTS] = q.en;
    end

    if (rst) begin
      d.mbox       = MBOX_RESET;
      d.full       = 1'b0;
      d.irq        = 1'b0;
      d.en         = ALERT_EN_RESET;
      d.gated_prev = '0;
      d.alert      = 1'b0;
      d.rdata      = 32'h0000_0000;
      d.rvalid     = 1'b0;
      d.upd_tgl    = 1'b0;
      d.upd_pend   = 1'b0;
      d.hold       = 5'h00;
      d.drn_s2     = 1'b0;
      d.drn_s3     = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // The word crosses by toggle; toggles are spaced by a hold-off, so the link
  // may briefly show an older word but always settles on the latest one.
  assign xfer.upd_tgl  = q.upd_tgl;
  assign xfer.upd_data = q.mbox;

  iomb_link u_link (
    .link_clk       (link_clk),
    .rst            (rst),
    .link_start     (link_start),
    .link_stop      (link_stop),
    .link_rd_strobe (link_rd_strobe),
    .link_wr_strobe (link_wr_strobe),
    .link_addr      (link_addr),
    .xfer           (xfer.link),
    .link_rdata     (link_rdata)
  );

  assign reg_rdata                = q.rdata;
  assign reg_rvalid               = q.rvalid;
  assign alert_flag_set           = q.alert;
  assign outbound_box_full_flag   = q.full;
  assign outbound_box_drained_irq = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_alert_gated_edge: assert property (
    alert_flag_set |-> $past(|(port_status & q.en & ~q.gated_prev)))
    else $error("alert without an enabled rising status");
  a_blocked_no_alert: assert property (
    (q.en == '0) && (q.gated_prev == '0) |=> !alert_flag_set)
    else $error("alert with every port disabled");
  a_enable_readback: assert property (
    reg_wr && sel_en ##1 reg_rd && sel_en && !reg_wr |=>
      reg_rdata[12:0] == $past(reg_wdata[12:0], 2))
    else $error("enable readback mismatch");
  a_reset_values: assert property (
    $fell(rst) |-> (q.mbox == 32'h0000_0000) && (q.en == 13'h1FFF) && !q.full)
    else $error("wrong reset values");
  a_mbox_write_data: assert property (
    reg_wr && sel_mbox |=> q.mbox == $past(reg_wdata))
    else $error("mailbox did not take the written word");
  a_write_sets_full: assert property (
    reg_wr && sel_mbox |=> outbound_box_full_flag)
    else $error("software write did not set full");
  a_drain_clears_full: assert property (
    drain_evt && !(reg_wr && sel_mbox) |=> !outbound_box_full_flag)
    else $error("drain did not clear full");
  a_irq_needs_full: assert property (
    outbound_box_drained_irq |-> $past(q.full) && $past(drain_evt))
    else $error("drained interrupt without prior full");
  a_irq_on_drain: assert property (
    drain_evt && q.full |=> outbound_box_drained_irq ##1 !outbound_box_drained_irq)
    else $error("drained interrupt missing or too long");

  c_write_then_drain: cover property (reg_wr && sel_mbox ##[1:200] outbound_box_drained_irq);
  c_alert_raised: cover property (alert_flag_set);
  c_enable_raise: cover property (reg_wr && sel_en ##1 alert_flag_set);
endmodule

// ---- iomb_link_master.sv ----
`timescale 1ns/1ps
module iomb_link_master (
  // Link clock
  input  wire logic       link_clk,
  // Byte-level events toward the slave
  output logic            link_start,
  output logic            link_stop,
  output logic            link_rd_strobe,
  output logic            link_wr_strobe,
  output logic      [7:0] link_addr,
  // Read data from the slave
  input  wire logic [7:0] link_rdata
);
  initial begin
    {link_start, link_stop, link_rd_strobe, link_wr_strobe} = 4'h0;
    link_addr = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One event per call: 0 start, 1 stop, 2 read, 3 write
  task automatic pulse(input int kind, input logic [7:0] a);
    @(posedge link_clk);
    #1;
    link_addr = a;
    case (kind)
      0: link_start = 1'b1;
      1: link_stop = 1'b1;
      2: link_rd_strobe = 1'b1;
      default: link_wr_strobe = 1'b1;
    endcase
    @(posedge link_clk);
    #1;
    {link_start, link_stop, link_rd_strobe, link_wr_strobe} = 4'h0;
    // Released address must not keep showing the old value
    link_addr = ~a;
  endtask

  // Data is registered at the taking edge, so it is settled here
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
    pulse(2, a);
    d = link_rdata;
  endtask
endmodule

// ---- iomb_top_tb.sv ----
`timescale 1ns/1ps
module iomb_top_tb;
  import iomb_pkg::*;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  link_clk = 1'b0;
  logic [REG_ADDR_W-1:0] reg_addr = '0;
  logic                  reg_wr = 1'b0;
  logic                  reg_rd = 1'b0;
  logic [REG_DATA_W-1:0] reg_wdata = '0;
  logic [REG_DATA_W-1:0] reg_rdata;
  logic                  reg_rvalid;
  logic [NUM_PORTS-1:0]  port_status = '0;
  logic                  alert_flag_set;
  logic                  outbound_box_full_flag;
  logic                  outbound_box_drained_irq;
  logic                  link_start, link_stop, link_rd_strobe, link_wr_strobe;
  logic [7:0]            link_addr, link_rdata;
  int                    errors, total_checks, irq_cnt, alert_cnt;
  int unsigned           mbox_m;
  bit                    full_m;

  initial forever #5 clk = ~clk;
  // Odd start offset keeps the link clock unrelated in phase
  initial begin
    #3.3;
    forever #16 link_clk = ~link_clk;
  end

  iomb_top i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .port_status(port_status), .alert_flag_set(alert_flag_set),
    .outbound_box_full_flag(outbound_box_full_flag),
    .outbound_box_drained_irq(outbound_box_drained_irq), .link_clk(link_clk),
    .link_start(link_start), .link_stop(link_stop), .link_rd_strobe(link_rd_strobe),
    .link_wr_strobe(link_wr_strobe), .link_addr(link_addr), .link_rdata(link_rdata));

  iomb_link_master i_master (.link_clk(link_clk), .link_start(link_start),
    .link_stop(link_stop), .link_rd_strobe(link_rd_strobe),
    .link_wr_strobe(link_wr_strobe), .link_addr(link_addr), .link_rdata(link_rdata));

  // Single-cycle pulses are counted so they cannot slip between checks
  always @(posedge clk) begin
    if (outbound_box_drained_irq === 1'b1) irq_cnt++;
    if (alert_flag_set === 1'b1) alert_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [REG_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
  endtask

  task automatic rdchk(input logic [REG_ADDR_W-1:0] a, input logic [31:0] exp);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    chk({31'h0, reg_rvalid}, 32'h1);
    chk(reg_rdata, exp);
  endtask

  // Write, then read back in the very next cycle
  task automatic wrrd(input logic [REG_ADDR_W-1:0] a, input logic [31:0] d,
                      input logic [31:0] exp);
    wr(a, d);
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    chk({31'h0, reg_rvalid}, 32'h1);
    chk(reg_rdata, exp);
  endtask

  task automatic clks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Whole frame: START, stray write, reads of first up to last, STOP
  task automatic frame(input logic [7:0] first, input logic [7:0] last);
    logic [7:0] b;
    int         e;
    repeat (10) @(posedge link_clk);
    i_master.pulse(0, 8'h00);
    i_master.pulse(3, LINK_MBOX_BASE);
    for (int a = first; a <= last; a++) begin
      e = (a <= 8'h93) ? (mbox_m >> (8 * (8'h93 - a))) & 8'hFF : 0;
      i_master.rd_byte(a[7:0], b);
      chk({24'h0, b}, e);
    end
    i_master.pulse(1, 8'h00);
    clks(40);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int e0;
    void'($urandom(19));
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    rdchk(MBOX_OFFSET, 32'h0);
    rdchk(ALERT_EN_OFFSET, 32'h0000_1FFF);
    rdchk(20'h1D2A0, 32'h0);
    chk({31'h0, outbound_box_full_flag}, 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 2; i++) begin
      mbox_m = $urandom;
      wr(MBOX_OFFSET, mbox_m);
      full_m = 1'b1;
      chk({31'h0, outbound_box_full_flag}, full_m);
    end
    wr(20'h1D2A0, ~mbox_m);
    rdchk(MBOX_OFFSET, mbox_m);
    $display("test mailbox write done");
    e0 = irq_cnt;
    frame(8'h90, 8'h94);
    full_m = 1'b0;
    chk({31'h0, outbound_box_full_flag}, full_m);
    chk(irq_cnt, e0 + 1);
    rdchk(MBOX_OFFSET, mbox_m);
    frame(8'h91, 8'h91);
    chk(irq_cnt, e0 + 1);
    $display("test link drain done");
    mbox_m = $urandom;
    wr(MBOX_OFFSET, mbox_m);
    frame(8'h95, 8'h95);
    chk({31'h0, outbound_box_full_flag}, 32'h1);
    chk(irq_cnt, e0 + 1);
    $display("test incomplete read done");
    for (int p = 0; p < NUM_PORTS; p++) begin
      wrrd(ALERT_EN_OFFSET, 32'h1FFF & ~(32'h1 << p), 32'h1FFF & ~(32'h1 << p));
      e0 = alert_cnt;
      port_status = 13'h1 << p;
      clks(6);
      chk(alert_cnt, e0);
      wrrd(ALERT_EN_OFFSET, 32'h1FFF, 32'h1FFF);
      clks(6);
      chk(alert_cnt, e0 + 1);
      rdchk(ALERT_EN_OFFSET, 32'h1FFF);
      port_status = '0;
      clks(2);
    end
    wrrd(ALERT_EN_OFFSET, 32'h0, 32'h0);
    e0 = alert_cnt;
    port_status = '1;
    clks(6);
    chk(alert_cnt, e0);
    wrrd(ALERT_EN_OFFSET, 32'hFFFF_FFFF, 32'h1FFF);
    clks(6);
    chk(alert_cnt, e0 + 1);
    port_status = '0;
    clks(2);
    port_status = 13'($urandom_range(8191, 1));
    clks(6);
    chk(alert_cnt, e0 + 2);
    $display("test alert enables done");
    summarize();
  end
endmodule
